// File: core/glc_link_config.v
// Purpose: low level link configuration registers of a Gen2 reader
// Assumes: host port decoder delivers address, data and write strobe
// Notes:   enable pin is asynchronous and is synchronised here
`timescale 1ns/1ps
`include "glc_defs.vh"

module glc_link_config #(
  parameter DELAY_STEP_CYCLES = `GLC_TX_DELAY_STEP_NS / `GLC_CLK_PERIOD_NS
) (
  input  wire        clock,
  input  wire        reset,
  input  wire        chip_enable,
  input  wire [4:0]  reg_addr,
  input  wire [7:0]  reg_wdata,
  input  wire        reg_we,
  output reg  [7:0]  reg_rdata,
  input  wire [1:0]  tari_sel,
  input  wire [1:0]  rx_coding,
  input  wire [1:0]  gain_steps,
  input  wire        cmd_valid,
  input  wire [7:0]  cmd_code,
  input  wire        rx_end,
  output reg  [10:0] pulse_width_cycles,
  output reg  [11:0] data_one_cycles,
  output wire [1:0]  pulse_width_sel,
  output wire [1:0]  data_one_len_sel,
  output wire        tx_crc5_sel,
  output wire        force_cal_period,
  output wire        session_sel_hi,
  output wire        session_sel_lo,
  output reg         cal_in_preamble,
  output reg  [1:0]  cmd_session,
  output wire [3:0]  link_freq_sel,
  output reg  [9:0]  link_freq_khz,
  output reg         link_freq_valid,
  output wire [1:0]  pilot_shorten,
  output reg  [6:0]  pilot_periods,
  output wire        long_preamble_sel,
  output reg         preamble_conflict,
  output wire [11:0] cal_period_count,
  output reg  [13:0] cal_period_cycles,
  output wire        gain_increase,
  output reg  [3:0]  gain_change_db,
  output wire        mixer_low_supply,
  output wire        io_low_voltage,
  output wire        open_drain_outputs,
  output reg         tx_delay_busy,
  output reg         tx_delay_done
);

  // ========================================================
  // derived cycle counts
  localparam integer TARI0_CYC = `GLC_TARI0_NS / `GLC_CLK_PERIOD_NS;
  localparam integer TARI1_CYC = `GLC_TARI1_NS / `GLC_CLK_PERIOD_NS;
  localparam integer TARI2_CYC = `GLC_TARI2_NS / `GLC_CLK_PERIOD_NS;
  localparam integer CAL_STEP_CYC =
    `GLC_CAL_STEP_NS / `GLC_CLK_PERIOD_NS;
  localparam integer GAIN_STEP = `GLC_GAIN_STEP_DB;

  localparam ST_IDLE = 1'b0;
  localparam ST_WAIT = 1'b1;

  // ========================================================
  // enable pin synchroniser
  reg chip_enable_s1_reg;
  reg chip_enable_s2_reg;
  wire preset;

  // resets to the enabled level so no stray preset follows reset
  always @(posedge clock)
  begin
    if (reset)
    begin
      chip_enable_s1_reg <= 1'b1;
      chip_enable_s2_reg <= 1'b1;
    end
    else
    begin
      chip_enable_s1_reg <= chip_enable;
      chip_enable_s2_reg <= chip_enable_s1_reg;
    end
  end

  // enable low presets the bank like a power-on reset
  assign preset = reset | ~chip_enable_s2_reg;

  // ========================================================
  // register bank
  reg [7:0] tx_symbol_options_reg;
  reg [7:0] rx_link_options_reg;
  reg [7:0] cal_period_low_reg;
  reg [7:0] cal_period_high_misc_reg;
  reg [7:0] delayed_tx_wait_reg;

  always @(posedge clock)
  begin
    if (preset)
    begin
      tx_symbol_options_reg    <= `GLC_RST_TX_SYMBOL;
      rx_link_options_reg      <= `GLC_RST_RX_LINK;
      cal_period_low_reg       <= `GLC_RST_CAL_LOW;
      cal_period_high_misc_reg <= `GLC_RST_CAL_HIGH;
      delayed_tx_wait_reg      <= `GLC_RST_DELAY_TX;
    end
    else if (reg_we)
    begin
      case (reg_addr)
        `GLC_ADDR_TX_SYMBOL: tx_symbol_options_reg <= reg_wdata;
        `GLC_ADDR_RX_LINK:   rx_link_options_reg <= reg_wdata;
        `GLC_ADDR_CAL_LOW:   cal_period_low_reg <= reg_wdata;
        `GLC_ADDR_CAL_HIGH:  cal_period_high_misc_reg <= reg_wdata;
        `GLC_ADDR_DELAY_TX:  delayed_tx_wait_reg <= reg_wdata;
        default:             tx_symbol_options_reg <= tx_symbol_options_reg;
      endcase
    end
  end

  // read data one cycle after the address; unmapped reads as zero
  always @(posedge clock)
  begin
    if (reset)
      reg_rdata <= 8'h00;
    else
    begin
      case (reg_addr)
        `GLC_ADDR_TX_SYMBOL: reg_rdata <= tx_symbol_options_reg;
        `GLC_ADDR_RX_LINK:   reg_rdata <= rx_link_options_reg;
        `GLC_ADDR_CAL_LOW:   reg_rdata <= cal_period_low_reg;
        `GLC_ADDR_CAL_HIGH:  reg_rdata <= cal_period_high_misc_reg;
        `GLC_ADDR_DELAY_TX:  reg_rdata <= delayed_tx_wait_reg;
        default:             reg_rdata <= 8'h00;
      endcase
    end
  end

  // ========================================================
  // field decode
  assign pulse_width_sel =
    tx_symbol_options_reg[`GLC_TX_PW_HI:`GLC_TX_PW_LO];
  assign data_one_len_sel =
    tx_symbol_options_reg[`GLC_TX_ONE_HI:`GLC_TX_ONE_LO];
  assign tx_crc5_sel      = tx_symbol_options_reg[`GLC_TX_CRC5];
  assign force_cal_period = tx_symbol_options_reg[`GLC_TX_FORCE_CAL];
  assign session_sel_hi   = tx_symbol_options_reg[`GLC_TX_S1];
  assign session_sel_lo   = tx_symbol_options_reg[`GLC_TX_S0];
  assign link_freq_sel    =
    rx_link_options_reg[`GLC_LINK_FREQ_SEL_HI:`GLC_LINK_FREQ_SEL_LO];
  assign pilot_shorten    =
    rx_link_options_reg[`GLC_RX_PIL_HI:`GLC_RX_PIL_LO];
  assign long_preamble_sel = rx_link_options_reg[`GLC_RX_LONG_PRE];
  assign cal_period_count = {cal_period_high_misc_reg[`GLC_CH_CAL_HI:
                             `GLC_CH_CAL_LO], cal_period_low_reg};
  assign gain_increase      =
    cal_period_high_misc_reg[`GLC_CH_GAIN_UP];
  assign mixer_low_supply   =
    cal_period_high_misc_reg[`GLC_CH_LOW_SUPPLY];
  assign io_low_voltage     =
    cal_period_high_misc_reg[`GLC_CH_IO_LOW];
  assign open_drain_outputs =
    cal_period_high_misc_reg[`GLC_CH_OPEN_DRAIN];

  // ========================================================
  // symbol timing in clock cycles
  reg [9:0]  tari_cyc;
  reg [7:0]  pw_hundredths;
  reg [7:0]  one_hundredths;
  reg [17:0] pw_product;
  reg [17:0] one_product;
  reg [17:0] pw_quot;
  reg [17:0] one_quot;

  always @*
  begin
    case (tari_sel)
      2'b00:   tari_cyc = TARI0_CYC[9:0];
      2'b01:   tari_cyc = TARI1_CYC[9:0];
      default: tari_cyc = TARI2_CYC[9:0];
    endcase
    case (pulse_width_sel)
      2'b00:   pw_hundredths = `GLC_PW_0;
      2'b01:   pw_hundredths = `GLC_PW_1;
      2'b10:   pw_hundredths = `GLC_PW_2;
      default: pw_hundredths = `GLC_PW_3;
    endcase
    case (data_one_len_sel)
      2'b00:   one_hundredths = `GLC_ONE_0;
      2'b01:   one_hundredths = `GLC_ONE_1;
      2'b10:   one_hundredths = `GLC_ONE_2;
      default: one_hundredths = `GLC_ONE_3;
    endcase
    pw_product  = tari_cyc * pw_hundredths;
    one_product = tari_cyc * one_hundredths;
    pw_quot     = pw_product / 18'h00064;
    one_quot    = one_product / 18'h00064;
  end

  // truncating divide: lengths round down to whole cycles
  always @(posedge clock)
  begin
    if (reset)
    begin
      pulse_width_cycles <= 11'h000;
      data_one_cycles    <= 12'h000;
      cal_period_cycles  <= 14'h0000;
    end
    else
    begin
      pulse_width_cycles <= pw_quot[10:0];
      data_one_cycles    <= one_quot[11:0];
      cal_period_cycles  <= cal_period_count * CAL_STEP_CYC[2:0];
    end
  end

  // ========================================================
  // receive link decode
  always @(posedge clock)
  begin
    if (reset)
    begin
      link_freq_khz     <= 10'h000;
      link_freq_valid   <= 1'b0;
      pilot_periods     <= 7'h00;
      preamble_conflict <= 1'b0;
      gain_change_db    <= 4'h0;
    end
    else
    begin
      link_freq_valid <= 1'b1;
      case (link_freq_sel)
        4'h0:    link_freq_khz <= 10'd40;
        4'h6:    link_freq_khz <= 10'd160;
        4'h9:    link_freq_khz <= 10'd256;
        4'hC:    link_freq_khz <= 10'd320;
        4'hF:    link_freq_khz <= 10'd640;
        default:
        begin
          link_freq_khz   <= 10'h000;
          link_freq_valid <= 1'b0;
        end
      endcase
      case (pilot_shorten)
        2'b00:   pilot_periods <= 7'd80;
        2'b01:   pilot_periods <= 7'd40;
        2'b10:   pilot_periods <= 7'd20;
        default: pilot_periods <= 7'd10;
      endcase
      // short preamble is meaningless with FM0 or Miller 2 decoding
      preamble_conflict <= ~long_preamble_sel & ~rx_coding[1];
      gain_change_db <= gain_steps * GAIN_STEP[1:0];
    end
  end

  // ========================================================
  // calibration period request per direct command
  always @(posedge clock)
  begin
    if (preset)
    begin
      cal_in_preamble <= 1'b0;
      cmd_session     <= 2'b00;
    end
    else
    begin
      cal_in_preamble <= 1'b0;
      if (cmd_valid)
      begin
        cmd_session <= {session_sel_hi, session_sel_lo};
        if (cmd_code == `GLC_CMD_QUERY)
          cal_in_preamble <= 1'b1;
        else if (force_cal_period &&
                 (cmd_code == `GLC_CMD_TX_CRC ||
                  cmd_code == `GLC_CMD_TX_NOCRC))
          cal_in_preamble <= 1'b1;
      end
    end
  end

  // ========================================================
  // delayed transmission timer
  reg        state_reg;
  reg        state_next;
  reg [15:0] step_cnt_reg;
  reg [15:0] step_cnt_next;
  reg [7:0]  steps_left_reg;
  reg [7:0]  steps_left_next;
  reg        done_next;

  always @*
  begin
    state_next      = state_reg;
    step_cnt_next   = step_cnt_reg;
    steps_left_next = steps_left_reg;
    done_next       = 1'b0;
    case (state_reg)
      ST_IDLE:
      begin
        // code zero leaves the timer idle
        if (rx_end && delayed_tx_wait_reg != 8'h00)
        begin
          state_next      = ST_WAIT;
          step_cnt_next   = 16'h0000;
          steps_left_next = delayed_tx_wait_reg;
        end
      end
      ST_WAIT:
      begin
        if (step_cnt_reg == DELAY_STEP_CYCLES[15:0] - 16'h0001)
        begin
          step_cnt_next = 16'h0000;
          if (steps_left_reg == 8'h01)
          begin
            state_next = ST_IDLE;
            done_next  = 1'b1;
          end
          steps_left_next = steps_left_reg - 8'h01;
        end
        else
          step_cnt_next = step_cnt_reg + 16'h0001;
      end
      default:
        state_next = ST_IDLE;
    endcase
  end

  always @(posedge clock)
  begin
    if (preset)
    begin
      state_reg      <= ST_IDLE;
      step_cnt_reg   <= 16'h0000;
      steps_left_reg <= 8'h00;
      tx_delay_done  <= 1'b0;
      tx_delay_busy  <= 1'b0;
    end
    else
    begin
      state_reg      <= state_next;
      step_cnt_reg   <= step_cnt_next;
      steps_left_reg <= steps_left_next;
      tx_delay_done  <= done_next;
      tx_delay_busy  <= (state_next == ST_WAIT);
    end
  end

endmodule // glc_link_config

// File: shared/glc_defs.vh
// Purpose: constants of the link configuration register bank
// Assumes: 40 MHz clock, byte wide register port
// Notes:   offsets are register addresses of the host port
`ifndef GLC_DEFS_VH
`define GLC_DEFS_VH

// ==========================================================
// register offsets
`define GLC_ADDR_TX_SYMBOL   5'h02
`define GLC_ADDR_RX_LINK     5'h03
`define GLC_ADDR_CAL_LOW     5'h04
`define GLC_ADDR_CAL_HIGH    5'h05
`define GLC_ADDR_DELAY_TX    5'h06

// ==========================================================
// reset values
`define GLC_RST_TX_SYMBOL    8'hF0
`define GLC_RST_RX_LINK      8'h60
`define GLC_RST_CAL_LOW      8'h35
`define GLC_RST_CAL_HIGH     8'h05
`define GLC_RST_DELAY_TX     8'h00

// ==========================================================
// field positions
`define GLC_TX_PW_HI         7
`define GLC_TX_PW_LO         6
`define GLC_TX_ONE_HI        5
`define GLC_TX_ONE_LO        4
`define GLC_TX_CRC5          3
`define GLC_TX_FORCE_CAL     2
`define GLC_TX_S1            1
`define GLC_TX_S0            0
`define GLC_LINK_FREQ_SEL_HI         7
`define GLC_LINK_FREQ_SEL_LO         4
`define GLC_RX_PIL_HI        3
`define GLC_RX_PIL_LO        2
`define GLC_RX_LONG_PRE      1
`define GLC_CH_GAIN_UP       7
`define GLC_CH_LOW_SUPPLY    6
`define GLC_CH_IO_LOW        5
`define GLC_CH_OPEN_DRAIN    4
`define GLC_CH_CAL_HI        3
`define GLC_CH_CAL_LO        0

// ==========================================================
// commands
`define GLC_CMD_QUERY        8'h98
`define GLC_CMD_TX_CRC       8'h90
`define GLC_CMD_TX_NOCRC     8'h91

// ==========================================================
// timing, in ns and hundredths of a Tari, and the gain step in dB
`define GLC_CLK_PERIOD_NS    25
`define GLC_TARI0_NS         6250
`define GLC_TARI1_NS         12500
`define GLC_TARI2_NS         25000
`define GLC_CAL_STEP_NS      100
`define GLC_TX_DELAY_STEP_NS 6400
`define GLC_PW_0             8'h1B
`define GLC_PW_1             8'h23
`define GLC_PW_2             8'h2C
`define GLC_PW_3             8'h32
`define GLC_ONE_0            8'h96
`define GLC_ONE_1            8'hA6
`define GLC_ONE_2            8'hB7
`define GLC_ONE_3            8'hC8
`define GLC_GAIN_STEP_DB     3

`endif

// File: test/glc_link_checker.sv
// Purpose: port checks of the link configuration bank
// Assumes: DELAY_STEP_CYCLES matches the design
// Notes:   derived outputs checked once their inputs held
`timescale 1ns/1ps
`include "glc_defs.vh"
// ==========
// checker
module glc_link_checker #(
  parameter DELAY_STEP_CYCLES = 256
) (
  input wire        clock,
  input wire        reset,
  input wire [4:0]  reg_addr,
  input wire [7:0]  reg_rdata,
  input wire [1:0]  rx_coding,
  input wire [1:0]  gain_steps,
  input wire [3:0]  gain_change_db,
  input wire        cmd_valid,
  input wire [7:0]  cmd_code,
  input wire        force_cal_period,
  input wire        session_sel_hi,
  input wire        session_sel_lo,
  input wire        cal_in_preamble,
  input wire [1:0]  cmd_session,
  input wire [1:0]  pilot_shorten,
  input wire [6:0]  pilot_periods,
  input wire        long_preamble_sel,
  input wire        preamble_conflict,
  input wire [11:0] cal_period_count,
  input wire [13:0] cal_period_cycles,
  input wire        tx_delay_busy,
  input wire        tx_delay_done
);
  logic        cal_req;
  logic [15:0] busy_cnt;
  assign cal_req = cmd_valid && (cmd_code == `GLC_CMD_QUERY ||
    force_cal_period && (cmd_code == `GLC_CMD_TX_CRC ||
    cmd_code == `GLC_CMD_TX_NOCRC));
  // length of the busy run, so a done can be tied to whole steps
  always @(posedge clock)
    if (reset)
      busy_cnt <= 16'h0000;
    else
      busy_cnt <= tx_delay_busy ? busy_cnt + 16'h0001 : 16'h0000;
  default clocking dcb @(posedge clock); endclocking
  default disable iff (reset);
  sequence s_busy_end;
    tx_delay_busy ##1 !tx_delay_busy;
  endsequence
  AST_CAL_PULSE:
    assert property (cal_in_preamble == $past(cal_req))
    else $error("calibration pulse wrong");
  AST_SESSION:
    assert property (cmd_valid |=> cmd_session ==
      $past({session_sel_hi, session_sel_lo}))
    else $error("session not captured");
  AST_UNMAPPED:
    assert property ((reg_addr < 5'h02 || reg_addr > 5'h06) |=>
      reg_rdata == 8'h00)
    else $error("unmapped read not zero");
  AST_CAL_CYCLES:
    assert property (!$past(reset) && $stable(cal_period_count) |->
      cal_period_cycles == {cal_period_count, 2'b00})
    else $error("calibration cycles wrong");
  AST_PREAMBLE:
    assert property (!$past(reset) && $stable(long_preamble_sel) &&
      $stable(rx_coding) |-> preamble_conflict ==
      (!long_preamble_sel && !rx_coding[1]))
    else $error("preamble flag wrong");
  AST_PILOT:
    assert property (!$past(reset) && $stable(pilot_shorten) |->
      pilot_periods == (7'h50 >> pilot_shorten))
    else $error("pilot periods wrong");
  AST_GAIN_DB:
    assert property (!$past(reset) && $stable(gain_steps) |->
      gain_change_db == {2'b00, gain_steps} * 4'h3)
    else $error("gain change wrong");
  AST_DONE_END:
    assert property (s_busy_end |-> tx_delay_done)
    else $error("busy ended without done");
  AST_BUSY_LEN:
    assert property (tx_delay_done |-> busy_cnt != 16'h0000 &&
      (busy_cnt % DELAY_STEP_CYCLES) == 16'h0000)
    else $error("delay not whole steps");
endmodule // glc_link_checker

// File: test/glc_host_model.sv
// Purpose: host side of the register port
// Assumes: called just after a rising edge
// Notes:   the strobe stands for one edge only
`timescale 1ns/1ps
// ==========
// host model
module glc_host_model (
  input  logic       clock,
  output logic [4:0] reg_addr,
  output logic [7:0] reg_wdata,
  output logic       reg_we
);
  initial
  begin
    reg_addr  = 5'h00;
    reg_wdata = 8'h00;
    reg_we    = 1'b0;
  end
  // idle edge after each write keeps two strobe edits apart
  task automatic wr(input logic [4:0] a, input logic [7:0] v);
    reg_addr  <= a;
    reg_wdata <= v;
    reg_we    <= 1'b1;
    @(posedge clock);
    reg_we    <= 1'b0;
    @(posedge clock);
  endtask
  task automatic point(input logic [4:0] a);
    reg_addr <= a;
  endtask
endmodule // glc_host_model

// File: test/testbench.sv
// Purpose: self checking bench of the link configuration bank
// Assumes: delay step cut to four clocks
// Notes:   drivers queue expectations, a watcher compares
`timescale 1ns/1ps
// ==========
// bench top
module testbench;
  localparam STEP = 4;
  logic        clock, reset, chip_enable, cmd_valid, rx_end, mark;
  logic [1:0]  tari_sel, rx_coding, gain_steps;
  logic [7:0]  cmd_code;
  logic [31:0] seed, d;
  int          failures = 0;
  int          tests_run = 0;
  int          cycles = 0;
  int          i, k;
  wire  [4:0]  reg_addr;
  wire  [7:0]  f02;
  wire  [6:0]  f03;
  wire  [3:0]  f05;
  wire  [7:0]  reg_wdata, reg_rdata;
  wire         reg_we, cal_pre, khz_ok, done;
  wire  [10:0] pw_cyc;
  wire  [11:0] one_cyc, cal_cnt;
  wire  [1:0]  sess;
  wire  [9:0]  khz;
  wire  [6:0]  pilot;
  wire  [13:0] cal_cyc;
  logic [15:0] exp_q[$];
  logic [3:0]  sel_q[$];
  logic [4:0]  adr[5] = '{5'h02, 5'h03, 5'h04, 5'h05, 5'h06};
  logic [7:0]  rst[5] = '{8'hF0, 8'h60, 8'h35, 8'h05, 8'h00};
  logic [7:0]  cmds[4] = '{8'h98, 8'h90, 8'h91, 8'h55};
  logic [3:0]  lf[6] = '{4'h0, 4'h6, 4'h9, 4'hC, 4'hF, 4'h3};
  int          kz[6] = '{40, 160, 256, 320, 640, 0};
  int          pw[4] = '{27, 35, 44, 50};
  int          one[4] = '{150, 166, 183, 200};
  glc_link_config #(.DELAY_STEP_CYCLES(STEP)) dut (
    .clock(clock), .reset(reset), .chip_enable(chip_enable),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_we(reg_we),
    .reg_rdata(reg_rdata), .tari_sel(tari_sel), .rx_coding(rx_coding),
    .gain_steps(gain_steps), .cmd_valid(cmd_valid), .cmd_code(cmd_code),
    .rx_end(rx_end), .pulse_width_cycles(pw_cyc),
    .data_one_cycles(one_cyc), .pulse_width_sel(f02[7:6]),
    .data_one_len_sel(f02[5:4]), .tx_crc5_sel(f02[3]),
    .force_cal_period(f02[2]), .session_sel_hi(f02[1]),
    .session_sel_lo(f02[0]), .cal_in_preamble(cal_pre), .cmd_session(sess),
    .link_freq_sel(f03[6:3]), .link_freq_khz(khz), .link_freq_valid(khz_ok),
    .pilot_shorten(f03[2:1]), .pilot_periods(pilot),
    .long_preamble_sel(f03[0]),
    .preamble_conflict(), .cal_period_count(cal_cnt),
    .cal_period_cycles(cal_cyc), .gain_increase(f05[3]), .gain_change_db(),
    .mixer_low_supply(f05[2]), .io_low_voltage(f05[1]),
    .open_drain_outputs(f05[0]),
    .tx_delay_busy(), .tx_delay_done(done));
  glc_host_model host (.clock(clock), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_we(reg_we));
  initial clock = 1'b0;
  always #12.5 clock = ~clock;
  function automatic logic [15:0] seen(input logic [3:0] s);
    case (s)
      4'h0: return {8'h00, reg_rdata};
      4'h1: return {5'h00, pw_cyc};
      4'h2: return {4'h0, one_cyc};
      4'h3: return {13'h0000, sess, cal_pre};
      4'h4: return {5'h00, khz_ok, khz};
      4'h5: return {9'h000, pilot};
      4'h6: return {4'h0, cal_cnt};
      4'h7: return {2'h0, cal_cyc};
      4'h8: return {1'b0, f02, f03};
      4'h9: return {12'h000, f05};
      default: return 16'h0000;
    endcase
  endfunction
  task automatic check(input logic [15:0] got, input logic [15:0] ex);
    tests_run++;
    if (got !== ex)
    begin
      failures++;
      $display("ERROR at %0t: saw %h expected %h", $time, got, ex);
    end
  endtask
  task automatic note(input logic [3:0] s, input logic [15:0] e);
    sel_q.push_back(s);
    exp_q.push_back(e);
  endtask
  task automatic look;
    mark <= 1'b1;
    @(posedge clock);
    mark <= 1'b0;
  endtask
  task automatic rd(input logic [4:0] a, input logic [7:0] e);
    host.point(a);
    @(posedge clock);
    note(4'h0, {8'h00, e});
    look;
  endtask
  task automatic close_out;
    $display("failures %0d tests_run %0d", failures, tests_run);
    if (failures == 0 && tests_run > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  always @(negedge clock)
    if (mark)
      while (sel_q.size() > 0)
        check(seen(sel_q.pop_front()), exp_q.pop_front());
  always @(posedge clock)
  begin
    cycles++;
    if (cycles == 2000)
    begin
      failures++;
      close_out;
    end
  end
  initial
  begin
    seed = 32'hFB5E;
    {reset, chip_enable, mark, cmd_valid, rx_end} = 5'b11000;
    {tari_sel, rx_coding, gain_steps, cmd_code} = 14'h0000;
    repeat (16) @(posedge clock);
    reset <= 1'b0;
    @(posedge clock);
    note(4'h6, 16'h0535);
    note(4'h7, 16'h14D4);
    look;
    for (i = 0; i < 5; i++)
      rd(adr[i], rst[i]);
    for (i = 0; i < 6; i++)
    begin
      d = $random(seed);
      host.wr(i < 5 ? adr[i] : 5'h07, d[7:0]);
      rd(i < 5 ? adr[i] : 5'h07, i < 5 ? d[7:0] : 8'h00);
    end
    host.wr(5'h02, d[31:24]);
    host.wr(5'h03, d[7:0]);
    host.wr(5'h04, d[15:8]);
    host.wr(5'h05, d[23:16]);
    note(4'h6, {4'h0, d[19:16], d[15:8]});
    note(4'h7, {2'h0, d[19:16], d[15:8], 2'b00});
    note(4'h8, {1'b0, d[31:24], d[7:1]});
    note(4'h9, {12'h000, d[23:20]});
    look;
    for (i = 0; i < 12; i++)
    begin
      tari_sel <= i[3:2];
      host.wr(5'h02, {i[1:0], i[1:0], 4'h0});
      @(posedge clock);
      k = 250 << i[3:2];
      note(4'h1, 16'(k * pw[i[1:0]] / 100));
      note(4'h2, 16'(k * one[i[1:0]] / 100));
      look;
    end
    // unlisted code 55 must never carry the calibration period
    for (i = 0; i < 8; i++)
    begin
      host.wr(5'h02, {5'h00, i[2], i[1:0]});
      d = $random(seed);
      {rx_coding, gain_steps} <= d[3:0];
      cmd_code <= cmds[i[1:0]];
      cmd_valid <= 1'b1;
      @(posedge clock);
      cmd_valid <= 1'b0;
      k = (i[1:0] == 2'h0) || (i[2] && i[1:0] != 2'h3);
      note(4'h3, {13'h0000, i[1:0], k[0]});
      look;
    end
    for (i = 0; i < 6; i++)
    begin
      host.wr(5'h03, {lf[i], i[1:0], 2'b00});
      note(4'h4, {5'h00, i < 5, 10'(kz[i])});
      note(4'h5, 16'(80 >> i[1:0]));
      look;
    end
    for (i = 0; i < 3; i++)
    begin
      host.wr(5'h06, 8'(i * 2));
      rx_end <= 1'b1;
      @(posedge clock);
      rx_end <= 1'b0;
      k = 0;
      while (done !== 1'b1 && k < 60)
      begin
        @(negedge clock);
        k++;
      end
      check(16'(k), 16'(i == 0 ? 60 : i * 2 * STEP + 1));
      @(posedge clock);
    end
    chip_enable <= 1'b0;
    repeat (4) @(posedge clock);
    host.wr(5'h02, 8'h12);
    for (i = 0; i < 5; i++)
      rd(adr[i], rst[i]);
    chip_enable <= 1'b1;
    close_out;
  end
endmodule // testbench

bind glc_link_config glc_link_checker #(
  .DELAY_STEP_CYCLES(DELAY_STEP_CYCLES)
) chk (
  .clock(clock), .reset(reset), .reg_addr(reg_addr),
  .reg_rdata(reg_rdata), .rx_coding(rx_coding), .cmd_valid(cmd_valid),
  .gain_steps(gain_steps), .gain_change_db(gain_change_db),
  .cmd_code(cmd_code), .force_cal_period(force_cal_period),
  .session_sel_hi(session_sel_hi), .session_sel_lo(session_sel_lo),
  .cal_in_preamble(cal_in_preamble), .cmd_session(cmd_session),
  .pilot_shorten(pilot_shorten), .pilot_periods(pilot_periods),
  .long_preamble_sel(long_preamble_sel),
  .preamble_conflict(preamble_conflict),
  .cal_period_count(cal_period_count),
  .cal_period_cycles(cal_period_cycles),
  .tx_delay_busy(tx_delay_busy), .tx_delay_done(tx_delay_done));
